// *** rtl/ndt_pkg.sv ***
// Package with register map, field layout and timing constants of the transmit control block.
// Operation
// - Burst limit field sets the most longwords moved in one DMA burst.
// - With single transfers on, a limit of 2 acts as 1 and 8 as 4.
// - After reset the burst limit holds one longword.
// - Fixed-ones fields read as ones and ignore writes.
// - Wake frames are watched for only while detection is switched on.
// - A seen wake frame sets its status flag and strobes low six cycles.
// - Single transfer mode limits each burst to one longword or octaword for limits of 1, 2, 4 and 8; other limits pass unchanged.
// - Setting transmit go enters RUNNING and scans from the current list position.
// - Running with no frame ready at the current position enters SUSPENDED.
// - A transmit start is honoured only from STOPPED.
// - Start stays STOPPED until the list base was written once.
// - Clearing transmit go finishes the current frame, then enters STOPPED.
// - Stop keeps the next descriptor position for the following start.
// - A transmit stop is honoured only in RUNNING or SUSPENDED.
// - With interrupts enabled, status bits one to six raise the interrupt where their mask bit is set.
package ndt_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_BASE   = 8'h0C;
  localparam logic [7:0] OFS_POS    = 8'h10;

  // ----------------------------------------------------------------
  // Mode control field positions and reset values
  // ----------------------------------------------------------------
  localparam int          BIT_IE      = 30;
  localparam int          BL_LSB      = 25;
  localparam int          BIT_WAKE_ON = 20;
  localparam int          BIT_SINGLE  = 19;
  localparam int          BIT_GO      = 11;
  localparam logic [31:0] ONES_MASK   = 32'h01E7_F000;
  localparam logic [3:0]  BL_RESET    = 4'h1;
  localparam logic [3:0]  BL_TWO      = 4'h2;
  localparam logic [3:0]  BL_FOUR     = 4'h4;
  localparam logic [3:0]  BL_EIGHT    = 4'h8;

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  localparam int         ST_TX_STOP = 1;
  localparam int         ST_TX_SUSP = 2;
  localparam int         ST_WAKE    = 3;
  localparam logic [6:1] IRQ_BITS   = 6'h3F;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         WAKE_STROBE_CYCLES = 6;
  localparam logic [2:0] WAKE_CNT_LOAD      = 3'(WAKE_STROBE_CYCLES);

  typedef enum logic [1:0] {
    TX_STOPPED,
    TX_RUNNING,
    TX_SUSPENDED
  } ndt_tx_state_t;

endpackage : ndt_pkg

// *** rtl/ndt_tx_ctrl.sv ***
// Mode control register, burst limit, wake strobe and transmit process control.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/100ps
module ndt_tx_ctrl
  import ndt_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        wake_frame_seen,
  input  wire logic        frame_ready,
  input  wire logic        frame_active,
  input  wire logic        desc_advance,
  input  wire logic [31:0] desc_next_pos,
  output logic      [3:0]  burst_max,
  output logic             single_transfer_bursts,
  output logic             tx_running,
  output logic      [1:0]  tx_state_code,
  output logic      [31:0] tx_cur_pos,
  output logic             wake_strobe_n,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic          int_enable;
  logic [3:0]    burst_limit;
  logic          wake_frame_detect_on;
  logic          transmit_go;
  logic [6:1]    status_reg;
  logic [6:1]    mask_reg;
  logic [31:0]   tx_list_base_reg;
  logic          base_written;
  logic [2:0]    wake_cnt;
  ndt_tx_state_t tx_state;
  ndt_tx_state_t next_tx_state;

  wire wr_mode   = reg_wr && (reg_addr == OFS_MODE);
  wire wr_status = reg_wr && (reg_addr == OFS_STATUS);
  wire wr_mask   = reg_wr && (reg_addr == OFS_MASK);
  wire wr_base   = reg_wr && (reg_addr == OFS_BASE);

  // A start is a 0 to 1 write of the go bit, a stop a 1 to 0 write.
  wire go_set   = wr_mode && reg_wdata[BIT_GO] && !transmit_go;
  wire go_clear = wr_mode && !reg_wdata[BIT_GO] && transmit_go;

  wire [31:0] mode_rd = ONES_MASK
                      | ({31'h0000_0000, int_enable} << BIT_IE)
                      | ({28'h000_0000, burst_limit} << BL_LSB)
                      | ({31'h0000_0000, wake_frame_detect_on} << BIT_WAKE_ON)
                      | ({31'h0000_0000, single_transfer_bursts} << BIT_SINGLE)
                      | ({31'h0000_0000, transmit_go} << BIT_GO);

  wire [31:0] rd_mux = (reg_addr == OFS_MODE)   ? mode_rd :
                       (reg_addr == OFS_STATUS) ? {25'h000_0000, status_reg, 1'b0} :
                       (reg_addr == OFS_MASK)   ? {25'h000_0000, mask_reg, 1'b0} :
                       (reg_addr == OFS_BASE)   ? tx_list_base_reg :
                       (reg_addr == OFS_POS)    ? tx_cur_pos : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      int_enable             <= 1'b0;
      burst_limit            <= BL_RESET;
      wake_frame_detect_on   <= 1'b0;
      single_transfer_bursts <= 1'b0;
      transmit_go            <= 1'b0;
      mask_reg               <= IRQ_BITS;
    end else begin
      if (wr_mode) begin
        int_enable             <= reg_wdata[BIT_IE];
        burst_limit            <= reg_wdata[BL_LSB +: 4];
        wake_frame_detect_on   <= reg_wdata[BIT_WAKE_ON];
        single_transfer_bursts <= reg_wdata[BIT_SINGLE];
        transmit_go            <= reg_wdata[BIT_GO];
      end
      if (wr_mask) begin
        mask_reg <= reg_wdata[6:1];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_list_base_reg <= 32'h0000_0000;
      base_written     <= 1'b0;
      reg_rdata        <= 32'h0000_0000;
    end else begin
      if (wr_base) begin
        tx_list_base_reg <= reg_wdata;
        base_written     <= 1'b1;
      end
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst limit
  // ----------------------------------------------------------------
  // In single transfer mode only 1 and 4 are legal; 2 folds to 1, 8 to 4.
  wire [3:0] bl_folded = (burst_limit == BL_TWO)   ? BL_RESET :
                         (burst_limit == BL_EIGHT) ? BL_FOUR : burst_limit;

  assign burst_max = single_transfer_bursts ? bl_folded : burst_limit;

  // ----------------------------------------------------------------
  // Wake frame flag and strobe
  // ----------------------------------------------------------------
  wire wake_hit = wake_frame_detect_on && wake_frame_seen;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_cnt <= 3'h0;
    end else if (wake_hit) begin
      wake_cnt <= WAKE_CNT_LOAD;
    end else if (wake_cnt != 3'h0) begin
      wake_cnt <= wake_cnt - 3'h1;
    end
  end

  assign wake_strobe_n = (wake_cnt == 3'h0);

  // ----------------------------------------------------------------
  // Transmit process
  // ----------------------------------------------------------------
  logic stop_pending;

  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      TX_STOPPED: begin
        if (go_set && base_written) begin
          next_tx_state = TX_RUNNING;
        end
      end
      TX_RUNNING: begin
        if (stop_pending && !frame_active) begin
          next_tx_state = TX_STOPPED;
        end else if (!frame_ready && !frame_active && !stop_pending) begin
          next_tx_state = TX_SUSPENDED;
        end
      end
      TX_SUSPENDED: begin
        if (stop_pending) begin
          next_tx_state = TX_STOPPED;
        end else if (frame_ready) begin
          next_tx_state = TX_RUNNING;
        end
      end
      default: next_tx_state = TX_STOPPED;
    endcase
  end

  // A stop command is remembered until the frame in flight ends.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_state     <= TX_STOPPED;
      stop_pending <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      if (next_tx_state == TX_STOPPED) begin
        stop_pending <= 1'b0;
      end else if (go_clear && tx_state != TX_STOPPED) begin
        stop_pending <= 1'b1;
      end
    end
  end

  // The position survives a stop, so a restart resumes where it left off.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_cur_pos <= 32'h0000_0000;
    end else if (wr_base) begin
      tx_cur_pos <= reg_wdata;
    end else if (desc_advance && tx_state != TX_STOPPED) begin
      tx_cur_pos <= desc_next_pos;
    end
  end

  assign tx_running    = (tx_state == TX_RUNNING);
  assign tx_state_code = tx_state;

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  wire [6:1] st_set = {3'b000, wake_hit,
                       tx_state == TX_RUNNING && next_tx_state == TX_SUSPENDED,
                       tx_state != TX_STOPPED && next_tx_state == TX_STOPPED};

  // A set in the same cycle as a write-one clear wins.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= 6'h00;
    end else begin
      status_reg <= (status_reg & ~(wr_status ? reg_wdata[6:1] : 6'h00)) | st_set;
    end
  end

  assign irq = int_enable && |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_fold;
    @(posedge mclk) disable iff (sys_rst)
      (single_transfer_bursts && burst_limit == BL_EIGHT) |-> burst_max == BL_FOUR;
  endproperty
  a_fold: assert property (p_fold) else $error("Burst limit not folded.");

  property p_limit;
    @(posedge mclk) disable iff (sys_rst)
      !single_transfer_bursts |-> burst_max == burst_limit;
  endproperty
  a_limit: assert property (p_limit) else $error("Burst limit not applied.");

  property p_ones;
    @(posedge mclk) disable iff (sys_rst)
      (reg_rd && reg_addr == OFS_MODE) |=> (reg_rdata & ONES_MASK) == ONES_MASK;
  endproperty
  a_ones: assert property (p_ones) else $error("Fixed ones read wrong.");

  property p_strobe;
    @(posedge mclk) disable iff (sys_rst)
      (wake_hit && wake_cnt == 3'h0) |=> !wake_strobe_n [*6] ##1 wake_strobe_n;
  endproperty
  a_strobe: assert property (p_strobe) else $error("Wake strobe length wrong.");

  property p_wake_off;
    @(posedge mclk) disable iff (sys_rst)
      (!wake_frame_detect_on && wake_cnt == 3'h0) |=> !status_reg[ST_WAKE] || $past(status_reg[ST_WAKE]);
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("Wake flag set while off.");

  property p_start;
    @(posedge mclk) disable iff (sys_rst)
      (tx_state == TX_STOPPED && go_set && base_written) |=> tx_state == TX_RUNNING;
  endproperty
  a_start: assert property (p_start) else $error("Start not taken.");

  property p_nobase;
    @(posedge mclk) disable iff (sys_rst)
      !base_written |=> tx_state == TX_STOPPED;
  endproperty
  a_nobase: assert property (p_nobase) else $error("Started without base.");

  property p_finish;
    @(posedge mclk) disable iff (sys_rst)
      (tx_state == TX_RUNNING && frame_active) |=> tx_state != TX_STOPPED;
  endproperty
  a_finish: assert property (p_finish) else $error("Stopped mid frame.");

  property p_susp;
    @(posedge mclk) disable iff (sys_rst)
      (tx_state == TX_RUNNING && !frame_ready && !frame_active && !stop_pending)
      |=> tx_state == TX_SUSPENDED;
  endproperty
  a_susp: assert property (p_susp) else $error("No suspend.");

  // Checked from the set event, so a broken status update or mask path is caught too.
  property p_irq;
    @(posedge mclk) disable iff (sys_rst)
      (int_enable && !wr_mode && !wr_mask && |(st_set & mask_reg)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt missing.");

  property p_single;
    @(posedge mclk) disable iff (sys_rst)
      single_transfer_bursts |-> (burst_max != BL_TWO) && (burst_max != BL_EIGHT);
  endproperty
  a_single: assert property (p_single) else $error("Single transfer limit wrong.");

  property p_pos_hold;
    @(posedge mclk) disable iff (sys_rst)
      (tx_state == TX_STOPPED && !wr_base) |=> $stable(tx_cur_pos);
  endproperty
  a_pos_hold: assert property (p_pos_hold) else $error("Position lost while stopped.");

  property p_idle_stop;
    @(posedge mclk) disable iff (sys_rst)
      tx_state == TX_STOPPED |=> !stop_pending;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("Stop taken while stopped.");

  property p_legal;
    @(posedge mclk) disable iff (sys_rst)
      tx_state_code != 2'h3;
  endproperty
  a_legal: assert property (p_legal) else $error("Illegal transmit state.");

  property p_wake_flag;
    @(posedge mclk) disable iff (sys_rst)
      wake_hit |=> status_reg[ST_WAKE];
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("Wake flag not set.");

endmodule : ndt_tx_ctrl

// *** dv/ndt_far_model.sv ***
// Far-side transmit engine model that serves frames from the descriptor list.
`timescale 1ns/100ps
module ndt_far_model
  import ndt_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        tx_running,
  input  wire logic [31:0] tx_cur_pos,
  input  wire logic        add_frame,
  input  wire logic        slow,
  output logic             frame_ready,
  output logic             frame_active,
  output logic             desc_advance,
  output logic      [31:0] desc_next_pos
);
  logic [3:0] queued;
  logic [3:0] left;

  assign frame_ready   = queued != 4'h0;
  assign desc_next_pos = tx_cur_pos + 32'h0000_0010;

  // The advance is given while the frame is still active, so it never meets a stop.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      queued       <= 4'h0;
      left         <= 4'h0;
      frame_active <= 1'b0;
      desc_advance <= 1'b0;
    end else begin
      desc_advance <= frame_active && left == 4'h1;
      if (add_frame) begin
        queued <= queued + 4'h1;
      end
      if (frame_active) begin
        left <= left - 4'h1;
        if (left == 4'h0) begin
          frame_active <= 1'b0;
          queued       <= queued - 4'h1;
        end
      end else if (tx_running && frame_ready) begin
        frame_active <= 1'b1;
        left         <= slow ? 4'h8 : 4'h2;
      end
    end
  end
endmodule : ndt_far_model

// *** dv/net_dma_burst_and_tx_control_bench.sv ***
// Self-checking testbench for the transmit control block.
`timescale 1ns/100ps
module net_dma_burst_and_tx_control_bench
  import ndt_pkg::*;
;
  localparam logic [31:0] KNOWN = 32'h5FFF_F800;
  logic        mclk, sys_rst, reg_wr, reg_rd, wake_frame_seen, add_frame, slow;
  logic        frame_ready, frame_active, desc_advance, single_transfer_bursts, tx_running, wake_strobe_n, irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, desc_next_pos, tx_cur_pos, rd, base, mode;
  logic [3:0]  burst_max, bl;
  logic [1:0]  tx_state_code;
  integer      failures, check_count, cycles, seed, i;

  ndt_tx_ctrl i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_frame_seen(wake_frame_seen),
    .frame_ready(frame_ready), .frame_active(frame_active), .desc_advance(desc_advance),
    .desc_next_pos(desc_next_pos), .burst_max(burst_max), .single_transfer_bursts(single_transfer_bursts),
    .tx_running(tx_running), .tx_state_code(tx_state_code), .tx_cur_pos(tx_cur_pos),
    .wake_strobe_n(wake_strobe_n), .irq(irq));
  ndt_far_model i_far (.mclk(mclk), .sys_rst(sys_rst), .tx_running(tx_running), .tx_cur_pos(tx_cur_pos),
    .add_frame(add_frame), .slow(slow), .frame_ready(frame_ready), .frame_active(frame_active),
    .desc_advance(desc_advance), .desc_next_pos(desc_next_pos));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      complete_run;
    end
  end

  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  task rdr(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdr

  task wait_state(input logic [1:0] s);
    int n;
    for (n = 0; n < 40; n++) begin
      #1;
      if (tx_state_code === s) break;
      @(posedge mclk);
    end
    chk("tx_state_code", {30'h0, s}, {30'h0, tx_state_code});
  endtask : wait_state

  task wake_pulse(input logic on);
    @(posedge mclk);
    wake_frame_seen <= 1'b1;
    @(posedge mclk);
    wake_frame_seen <= 1'b0;
    for (int n = 0; n < 7; n++) begin
      #1 chk("wake_strobe_n", {31'h0, n == 6 || !on}, {31'h0, wake_strobe_n});
      @(posedge mclk);
    end
  endtask : wake_pulse

  function automatic logic [3:0] fold(input logic [3:0] b, input logic s);
    return (s && b == BL_TWO) ? BL_RESET : (s && b == BL_EIGHT) ? BL_FOUR : b;
  endfunction : fold

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'ha4f33358;
    failures = 0;
    check_count = 0;
    cycles = 0;
    {sys_rst, reg_wr, reg_rd, wake_frame_seen, add_frame, slow} = 6'b10_0000;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rdr(OFS_MODE);
    chk("mode", ((32'(BL_RESET) << BL_LSB) | ONES_MASK) & KNOWN, rd & KNOWN);
    chk("burst_max", 32'h0000_0001, {28'h0, burst_max});
    wait_state(TX_STOPPED);
    rdr(OFS_MASK);
    chk("mask", 32'h0000_007E, rd & 32'h0000_007E);
    rdr(8'h20);
    chk("unmapped", 32'h0000_0000, rd);
    // Zeros written into the fixed-ones fields must still read back as ones.
    for (i = 0; i < 8; i++) begin
      bl = 4'h1 << i[1:0];
      mode = ($random(seed) & (ONES_MASK | 32'h4000_0000)) | (32'(i[2]) << BIT_SINGLE) | (32'(bl) << BL_LSB);
      wr(OFS_MODE, mode);
      rdr(OFS_MODE);
      chk("mode", (mode | ONES_MASK) & KNOWN, rd & KNOWN);
      chk("burst_max", {28'h0, fold(bl, i[2])}, {28'h0, burst_max});
      chk("single", {31'h0, i[2]}, {31'h0, single_transfer_bursts});
    end
    mode = 32'h0200_0000;
    wr(OFS_MODE, mode | 32'h0000_0800);
    repeat (3) @(posedge mclk);
    wait_state(TX_STOPPED);
    wr(OFS_MODE, mode);
    base = $random(seed) & 32'hFFFF_FFF0;
    wr(OFS_BASE, base);
    wr(OFS_MODE, mode | 32'h0000_0800);
    wait_state(TX_RUNNING);
    wait_state(TX_SUSPENDED);
    rdr(OFS_POS);
    chk("pos", base, rd);
    rdr(OFS_BASE);
    chk("base", base, rd);
    rdr(OFS_STATUS);
    chk("susp_flag", 32'h0000_0001, {31'h0, rd[ST_TX_SUSP]});
    slow <= 1'b1;
    @(posedge mclk);
    add_frame <= 1'b1;
    @(posedge mclk);
    add_frame <= 1'b0;
    wait_state(TX_RUNNING);
    wr(OFS_MODE, mode);
    #1 chk("frame_active", 32'h0000_0001, {31'h0, frame_active});
    wait_state(TX_RUNNING);
    wait_state(TX_STOPPED);
    chk("frame_active", 32'h0000_0000, {31'h0, frame_active});
    rdr(OFS_STATUS);
    chk("stop_flag", 32'h0000_0001, {31'h0, rd[ST_TX_STOP]});
    chk("tx_cur_pos", base + 32'h0000_0010, tx_cur_pos);
    wr(OFS_MODE, mode | 32'h0000_0800);
    wait_state(TX_RUNNING);
    chk("tx_cur_pos", base + 32'h0000_0010, tx_cur_pos);
    wr(OFS_MODE, mode);
    wait_state(TX_STOPPED);
    wr(OFS_STATUS, 32'h0000_007E);
    wake_pulse(1'b0);
    rdr(OFS_STATUS);
    chk("wake_flag", 32'h0000_0000, {31'h0, rd[ST_WAKE]});
    mode = 32'h4210_0000;
    wr(OFS_MODE, mode);
    #1 chk("irq", 32'h0000_0000, {31'h0, irq});
    wake_pulse(1'b1);
    rdr(OFS_STATUS);
    chk("wake_flag", 32'h0000_0001, {31'h0, rd[ST_WAKE]});
    chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(OFS_MASK, 32'h0000_0000);
    #1 chk("irq", 32'h0000_0000, {31'h0, irq});
    wr(OFS_MASK, 32'h0000_007E);
    #1 chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(OFS_STATUS, 32'h0000_0008);
    #1 chk("irq", 32'h0000_0000, {31'h0, irq});
    complete_run;
  end
endmodule : net_dma_burst_and_tx_control_bench
